/* hdl/scfp_port.sv */
// One channel's host FIFO port. Assumes the protocol engine on the
// serial side pushes received bytes and pops released transmit bytes.
`timescale 1ns/1ps
module scfp_port #(
  parameter logic [7:0] LOW_ADDR = scfp_pkg::FIFO_LOW_A
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Host bus, one access per strobe cycle
  input wire logic bus_wide,
  input wire logic [7:0] addr,
  input wire logic rd_stb,
  input wire logic wr_stb,
  input wire logic byte_access,
  input wire logic [15:0] wr_data,
  output logic [15:0] rd_data,
  output logic rd_hit,
  // Configuration and commands
  input wire logic [1:0] receive_threshold_field,
  input wire scfp_pkg::scfp_proto_t proto,
  input wire logic dma_enable_bit,
  input wire logic receive_message_complete_cmd,
  input wire logic transmit_frame_cmd,
  // Serial engine, receive
  input wire logic eng_rx_valid,
  input wire logic [7:0] eng_rx_byte,
  input wire logic eng_rx_end,
  output logic eng_rx_ready,
  // Serial engine, transmit
  input wire logic eng_tx_pop,
  output logic [7:0] eng_tx_byte,
  output logic eng_tx_avail,
  // Events and status
  output logic receive_pool_full_event,
  output logic receive_message_end_event,
  output logic transmit_pool_ready_event,
  output logic [5:0] receive_byte_count,
  // DMA requests
  output logic dma_receive_request,
  output logic dma_transmit_request
);

  // --------------------------------------------------------------
  // Address decode and access size
  // --------------------------------------------------------------
  logic hit;
  logic rx_pop, rx_two, tx_push, tx_two;
  logic [5:0] rx_count, tx_count;
  logic [15:0] rx_out, tx_out;
  logic [5:0] level;

  // Both data bytes decode at LOW_ADDR and LOW_ADDR + 1; no increment happens
  assign hit = (addr == LOW_ADDR) || (addr == 8'(LOW_ADDR + 8'h01));
  assign rd_hit = rd_stb && hit;
  assign rx_pop = rd_hit && rx_count != 6'h00;
  assign rx_two = bus_wide && !byte_access && rx_count > 6'h01;
  assign tx_push = wr_stb && hit;
  assign tx_two = bus_wide && !byte_access;

  // --------------------------------------------------------------
  // Threshold decode
  // --------------------------------------------------------------
  always_comb begin
    level = 6'd32;
    if (proto == scfp_pkg::SCFP_PROTO_FRAMED) begin
      case (receive_threshold_field)
        2'h0: level = 6'd32;
        2'h1: level = 6'd16;
        2'h2: level = 6'd4;
        default: level = 6'd2;
      endcase
    end else begin
      case (receive_threshold_field)
        2'h0: level = 6'd1;
        2'h1: level = 6'd4;
        2'h2: level = 6'd16;
        default: level = 6'd32;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Receive control
  // --------------------------------------------------------------
  scfp_pkg::scfp_rx_state_t rx_st_q, rx_st_d;
  logic [5:0] frm_q, frm_d;
  logic full_q, full_d, mend_q, mend_d;
  logic [5:0] rbc_q, rbc_d;
  logic rx_flush;

  assign eng_rx_ready = rx_st_q == scfp_pkg::SCFP_RX_FILL &&
                        rx_count < 6'd32;
  assign rx_flush = receive_message_complete_cmd;

  always_comb begin
    rx_st_d = rx_st_q;
    frm_d = frm_q;
    rbc_d = rbc_q;
    full_d = 1'b0;
    mend_d = 1'b0;
    // Bytes of the whole frame, across threshold blocks
    if (eng_rx_valid && eng_rx_ready) begin
      frm_d = 6'(frm_q + 6'h01);
    end
    case (rx_st_q)
      scfp_pkg::SCFP_RX_FILL: begin
        if (eng_rx_valid && eng_rx_ready && eng_rx_end) begin
          mend_d = !dma_enable_bit;
          rbc_d = 6'(frm_q + 6'h01);
          frm_d = scfp_pkg::CNT_ZERO;
          rx_st_d = scfp_pkg::SCFP_RX_HELD;
        end else if (eng_rx_valid && eng_rx_ready &&
                     6'(rx_count + 6'h01) >= level) begin
          full_d = !dma_enable_bit;
          rx_st_d = scfp_pkg::SCFP_RX_HELD;
        end
      end
      scfp_pkg::SCFP_RX_HELD: begin
        if (rx_flush) begin
          rx_st_d = scfp_pkg::SCFP_RX_FILL;
        end else if (rx_count == 6'h00) begin
          rx_st_d = scfp_pkg::SCFP_RX_DRAIN;
        end
      end
      scfp_pkg::SCFP_RX_DRAIN: begin
        if (rx_flush) begin
          rx_st_d = scfp_pkg::SCFP_RX_FILL;
        end
      end
      default: rx_st_d = scfp_pkg::SCFP_RX_FILL;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_st_q <= scfp_pkg::SCFP_RX_FILL;
      frm_q <= scfp_pkg::CNT_ZERO;
      full_q <= 1'b0;
      mend_q <= 1'b0;
      rbc_q <= scfp_pkg::CNT_ZERO;
    end else begin
      rx_st_q <= rx_st_d;
      frm_q <= frm_d;
      full_q <= full_d;
      mend_q <= mend_d;
      rbc_q <= rbc_d;
    end
  end

  assign receive_pool_full_event = full_q;
  assign receive_message_end_event = mend_q;
  assign receive_byte_count = rbc_q;

  // Held until the read that takes the last bytes of the block begins
  assign dma_receive_request = dma_enable_bit &&
    rx_st_q == scfp_pkg::SCFP_RX_HELD && rx_count != 6'h00 &&
    !(rd_hit && rx_count <= (rx_two ? 6'h02 : 6'h01));

  scfp_queue u_rx (
    .clk(clk),
    .rst(rst),
    .flush(rx_flush),
    .push(eng_rx_valid && eng_rx_ready),
    .push_two(1'b0),
    .push_data({8'h00, eng_rx_byte}),
    .pop(rx_pop),
    .pop_two(rx_two),
    .pop_data(rx_out),
    .count(rx_count)
  );

  logic [15:0] rdat_q, rdat_d;
  always_comb begin
    rdat_d = rdat_q;
    if (rx_pop) begin
      rdat_d = rx_two ? rx_out : {8'h00, rx_out[7:0]};
    end
  end

  // --------------------------------------------------------------
  // Transmit control
  // --------------------------------------------------------------
  logic [5:0] rel_q, rel_d;
  logic xpr_q, xpr_d;
  logic [5:0] tx_room;

  assign tx_room = 6'(6'd32 - tx_count);
  assign eng_tx_avail = rel_q != 6'h00;
  assign eng_tx_byte = tx_out[7:0];
  assign dma_transmit_request = dma_enable_bit && rel_q == 6'h00 &&
    tx_room != 6'h00 &&
    !(tx_push && tx_room <= (tx_two ? 6'h02 : 6'h01));

  always_comb begin
    rel_d = rel_q;
    xpr_d = 1'b0;
    if (transmit_frame_cmd) begin
      rel_d = tx_count;
    end else if (eng_tx_pop && rel_q != 6'h00) begin
      rel_d = 6'(rel_q - 6'h01);
      xpr_d = rel_q == 6'h01 && !dma_enable_bit;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rel_q <= scfp_pkg::CNT_ZERO;
      xpr_q <= 1'b0;
      rdat_q <= 16'h0000;
    end else begin
      rel_q <= rel_d;
      xpr_q <= xpr_d;
      rdat_q <= rdat_d;
    end
  end

  assign transmit_pool_ready_event = xpr_q;
  assign rd_data = rdat_q;

  scfp_queue u_tx (
    .clk(clk),
    .rst(rst),
    .flush(1'b0),
    .push(tx_push && tx_room != 6'h00),
    .push_two(tx_two && tx_room > 6'h01),
    .push_data(wr_data),
    .pop(eng_tx_pop && rel_q != 6'h00),
    .pop_two(1'b0),
    .pop_data(tx_out),
    .count(tx_count)
  );

endmodule

/* hdl/scfp_pkg.sv */
// Constants shared by the serial channel FIFO host port.
// Assumes a single 50 MHz clock and a synchronous active-high reset.
package scfp_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] FIFO_LOW_A = 8'h10;
  localparam logic [7:0] FIFO_HIGH_A = 8'h11;
  localparam logic [7:0] FIFO_LOW_B = 8'h60;
  localparam logic [7:0] FIFO_HIGH_B = 8'h61;

  // ------------------------------------------------------------
  // Sizes and reset values
  // ------------------------------------------------------------
  localparam int QUEUE_DEPTH = 32;
  localparam logic [1:0] THRESH_RESET = 2'h0;
  localparam logic [5:0] CNT_ZERO = 6'h00;

  typedef enum logic [1:0] {
    SCFP_PROTO_FRAMED = 2'h0,
    SCFP_PROTO_ASYNC = 2'h1,
    SCFP_PROTO_BYTESYNC = 2'h2
  } scfp_proto_t;

  // Receive side states, Gray coded along the usual path
  typedef enum logic [1:0] {
    SCFP_RX_FILL = 2'b00,
    SCFP_RX_HELD = 2'b01,
    SCFP_RX_DRAIN = 2'b11
  } scfp_rx_state_t;

endpackage

/* hdl/scfp_queue.sv */
// One 32-byte queue held in flip-flops, with one or two byte pushes or
// pops per cycle. Assumes callers never push past full or pop past empty.
`timescale 1ns/1ps
module scfp_queue (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Flush all contents
  input wire logic flush,
  // Push side
  input wire logic push,
  input wire logic push_two,
  input wire logic [15:0] push_data,
  // Pop side
  input wire logic pop,
  input wire logic pop_two,
  output logic [15:0] pop_data,
  // Fill level
  output logic [5:0] count
);

  logic [7:0] mem_q [scfp_pkg::QUEUE_DEPTH];
  logic [7:0] mem_d [scfp_pkg::QUEUE_DEPTH];
  logic [4:0] wr_q, wr_d, rd_q, rd_d;
  logic [5:0] cnt_q, cnt_d;
  logic [4:0] rd_n;

  assign rd_n = rd_q + 5'h01;
  assign pop_data = {mem_q[rd_n], mem_q[rd_q]};
  assign count = cnt_q;

  always_comb begin
    logic [5:0] inc;
    logic [5:0] dec;
    inc = 6'h00;
    dec = 6'h00;
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    if (push) begin
      mem_d[wr_q] = push_data[7:0];
      if (push_two) begin
        mem_d[5'(wr_q + 5'h01)] = push_data[15:8];
      end
      inc = push_two ? 6'h02 : 6'h01;
      wr_d = wr_q + inc[4:0];
    end
    if (pop) begin
      dec = pop_two ? 6'h02 : 6'h01;
      rd_d = rd_q + dec[4:0];
    end
    cnt_d = cnt_q + inc - dec;
    if (flush) begin
      wr_d = 5'h00;
      rd_d = 5'h00;
      cnt_d = scfp_pkg::CNT_ZERO;
    end
  end

  genvar i;
  generate
    for (i = 0; i < scfp_pkg::QUEUE_DEPTH; i++) begin : g_mem
      always_ff @(posedge clk) begin
        mem_q[i] <= mem_d[i];
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q <= 5'h00;
      rd_q <= 5'h00;
      cnt_q <= scfp_pkg::CNT_ZERO;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

endmodule

/* verif/scfp_monitor.sv */
// Checker on one channel of the FIFO host port.
// Assumes mode inputs stay steady while a frame is in flight.
`timescale 1ns/1ps
module scfp_monitor (
  // Clock, reset, mode and commands
  input wire logic clk,
  input wire logic rst,
  input wire logic dma_enable_bit,
  input wire logic receive_message_complete_cmd,
  input wire logic transmit_frame_cmd,
  // Engine side, events and requests
  input wire logic eng_rx_ready,
  input wire logic eng_tx_avail,
  input wire logic receive_pool_full_event,
  input wire logic receive_message_end_event,
  input wire logic [5:0] receive_byte_count,
  input wire logic dma_receive_request,
  input wire logic dma_transmit_request
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic rel_q, rel_d;
  always_comb rel_d = !rst && (rel_q || transmit_frame_cmd);
  always_ff @(posedge clk) rel_q <= rel_d;
  sequence s_end_held;
    receive_message_end_event && !receive_message_complete_cmd;
  endsequence
  sequence s_full;
    $rose(receive_pool_full_event);
  endsequence
  a_held_push: assert property (
    s_end_held |=> !eng_rx_ready) else $error("push while held");
  a_full_pulse: assert property (
    s_full |=> (!receive_pool_full_event) [*2]) else $error("long event");
  a_irq_only: assert property (
    dma_enable_bit && $past(dma_enable_bit)
    |-> !receive_pool_full_event && !receive_message_end_event)
    else $error("event in dma mode");
  a_rx_req: assert property (
    !dma_enable_bit |-> !dma_receive_request) else $error("rx request");
  a_tx_req: assert property (
    !dma_enable_bit |-> !dma_transmit_request) else $error("tx request");
  a_end_pulse: assert property (
    receive_message_end_event |=> !receive_message_end_event)
    else $error("long end event");
  a_end_count: assert property (
    receive_message_end_event |-> receive_byte_count != 6'h00)
    else $error("empty end count");
  a_tx_release: assert property (
    eng_tx_avail |-> rel_q || transmit_frame_cmd)
    else $error("send before release");
endmodule

/* verif/scfp_eng_model.sv */
// Serial engine model: pushes one frame, pops released bytes.
// Assumes go is a one-cycle pulse given while idle.
`timescale 1ns/1ps
module scfp_eng_model (
  // Clock, reset and bench control
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic slow,
  input wire logic [5:0] len,
  input wire logic [7:0] base,
  // Engine handshake
  input wire logic rdy,
  input wire logic avail,
  output logic vld,
  output logic [7:0] dat,
  output logic last,
  output logic pop
);
  logic [5:0] idx = 6'h00;
  logic ph = 1'b0;
  logic [7:0] cur;
  initial vld = 1'b0;
  assign cur = base + {2'h0, idx};
  // Idle byte is inverted so a stale value cannot pass
  assign dat = vld ? cur : ~cur;
  assign last = vld && idx + 6'h01 == len;
  assign pop = avail && (!slow || ph);
  always @(posedge clk) begin
    ph <= ~ph;
    if (rst || go)
      idx <= 6'h00;
    else if (vld && rdy)
      idx <= idx + 6'h01;
    if (rst || (vld && rdy && last))
      vld <= 1'b0;
    else if (go)
      vld <= 1'b1;
  end
endmodule

/* verif/testbench.sv */
// Bench for one channel of the FIFO host port.
// Assumes a 16-bit host bus, switched to 8 bits for one transmit frame, and the channel B address pair.
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] LA = scfp_pkg::FIFO_LOW_B;
  localparam int FT[4] = '{32, 16, 4, 2};
  localparam int AT[4] = '{1, 4, 16, 32};
  logic clk = 1'b0, rst = 1'b1, rds = 1'b0, wrs = 1'b0, bw = 1'b0;
  logic dma = 1'b0, cmpl = 1'b0, send = 1'b0, go = 1'b0, slow = 1'b0;
  logic wide = 1'b1;
  logic [7:0] addr = 8'h00, base = 8'h00, rxb, txb, txq[$];
  logic [15:0] wd = 16'h0000, rdd;
  logic [1:0] thf = 2'h0;
  logic [5:0] len = 6'h00, rbc;
  scfp_pkg::scfp_proto_t pr = scfp_pkg::SCFP_PROTO_FRAMED;
  logic hit, rxv, rxe, rxr, txp, txa, pfull, mend, tpr, rreq, treq;
  logic [31:0] s = 32'h0000003b;
  int num_errors = 0, num_checks = 0, npush = 0, n;
  always #10 clk = ~clk;
  always @(posedge clk) begin
    if (rxv && rxr)
      npush++;
    if (txp)
      txq.push_back(txb);
  end
  scfp_port #(.LOW_ADDR(LA)) i_scfp_port (.clk(clk), .rst(rst),
    .bus_wide(wide), .addr(addr), .rd_stb(rds), .wr_stb(wrs),
    .byte_access(bw), .wr_data(wd), .rd_data(rdd), .rd_hit(hit),
    .receive_threshold_field(thf), .proto(pr), .dma_enable_bit(dma),
    .receive_message_complete_cmd(cmpl), .transmit_frame_cmd(send),
    .eng_rx_valid(rxv), .eng_rx_byte(rxb), .eng_rx_end(rxe),
    .eng_rx_ready(rxr), .eng_tx_pop(txp), .eng_tx_byte(txb),
    .eng_tx_avail(txa), .receive_pool_full_event(pfull),
    .receive_message_end_event(mend), .transmit_pool_ready_event(tpr),
    .receive_byte_count(rbc), .dma_receive_request(rreq),
    .dma_transmit_request(treq));
  scfp_eng_model i_scfp_eng_model (.clk(clk), .rst(rst), .go(go),
    .slow(slow), .len(len), .base(base), .rdy(rxr), .avail(txa),
    .vld(rxv), .dat(rxb), .last(rxe), .pop(txp));
  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  function automatic int thr(int p, int c);
    return p == 0 ? FT[c] : AT[c];
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wev(input int k);
    logic [4:0] v;
    for (n = 0; n < 400; n++) begin
      @(negedge clk);
      v = {treq, rreq, tpr, mend, pfull};
      if (v[k] === 1'b1)
        break;
    end
    if (n == 400) begin
      num_errors++;
      $display("CHECK FAILED %0t wait timed out", $time);
      wrap_up();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic b, output logic [15:0] d,
    output logic h);
    @(posedge clk);
    addr <= a;
    bw <= b;
    rds <= 1'b1;
    @(negedge clk);
    h = hit;
    @(posedge clk);
    rds <= 1'b0;
    @(negedge clk);
    d = rdd;
  endtask
  task automatic wr(input logic [15:0] d, input logic b);
    @(posedge clk);
    addr <= LA;
    bw <= b;
    wd <= d;
    wrs <= 1'b1;
    @(posedge clk);
    wrs <= 1'b0;
  endtask
  task automatic cmd(input logic x);
    @(posedge clk);
    cmpl <= x;
    send <= !x;
    @(posedge clk);
    cmpl <= 1'b0;
    send <= 1'b0;
  endtask
  task automatic rdn(input int f, input int c);
    logic [15:0] d;
    logic h;
    for (int i = f; i < f + c; i += 2) begin
      rd(LA, f + c - i == 1, d, h);
      chk(d[7:0], 8'(base + i));
      if (f + c - i > 1)
        chk(d[15:8], 8'(base + i + 1));
    end
  endtask
  task automatic frame(input int p, input int c, input int l);
    @(posedge clk);
    pr <= scfp_pkg::scfp_proto_t'(p);
    thf <= 2'(c);
    len <= 6'(l);
    base <= 8'(rnd());
    slow <= s[9];
    go <= 1'b1;
    npush = 0;
    @(posedge clk);
    go <= 1'b0;
  endtask
  initial begin
    logic [15:0] d, e;
    logic [7:0] b;
    logic h;
    int t, k;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(rdd, 16'h0000);
    for (int p = 0; p < 3; p++) begin
      for (int c = 0; c < 4; c++) begin
        t = thr(p, c);
        frame(p, c, t + 1);
        wev(0);
        rdn(0, t);
        chk(16'(npush), 16'(t));
        cmd(1'b1);
        wev(1);
        chk(16'(rbc), 16'(t + 1));
        rdn(t, 1);
        cmd(1'b1);
      end
    end
    $display("receive frames done");
    b = 8'(rnd());
    wr({b + 8'h01, b}, 1'b0);
    wr({b + 8'h03, b + 8'h02}, 1'b0);
    wr({8'h00, b + 8'h04}, 1'b1);
    repeat (3) @(negedge clk);
    chk(16'(txa), 16'h0000);
    cmd(1'b0);
    wev(2);
    chk(16'(txq.size()), 16'h0005);
    for (int i = 0; i < 5; i++)
      chk(16'(txq[i]), 16'(8'(b + i)));
    @(posedge clk);
    wide <= 1'b0;
    wr({b + 8'h06, b + 8'h05}, 1'b0);
    cmd(1'b0);
    wev(2);
    chk(16'(txq.size()), 16'h0006);
    chk(16'(txq[5]), 16'(8'(b + 8'h05)));
    $display("transmit frame done");
    @(posedge clk);
    wide <= 1'b1;
    dma <= 1'b1;
    wev(4);
    frame(0, 2, 4);
    wev(3);
    for (k = 0; k < 8 && rreq === 1'b1; k++)
      rdn(2 * k, 2);
    chk(16'(k), 16'h0002);
    cmd(1'b1);
    rd(LA + 8'h01, 1'b0, d, h);
    chk(16'(h), 16'h0001);
    rd(LA + 8'h02, 1'b0, e, h);
    chk(16'(h), 16'h0000);
    chk(e, d);
    chk(d, {base + 8'h03, base + 8'h02});
    $display("dma and decode done");
    wrap_up();
  end
endmodule
bind scfp_port scfp_monitor i_scfp_monitor (.clk(clk), .rst(rst),
  .dma_enable_bit(dma_enable_bit),
  .receive_message_complete_cmd(receive_message_complete_cmd),
  .transmit_frame_cmd(transmit_frame_cmd), .eng_rx_ready(eng_rx_ready),
  .eng_tx_avail(eng_tx_avail),
  .receive_pool_full_event(receive_pool_full_event),
  .receive_message_end_event(receive_message_end_event),
  .receive_byte_count(receive_byte_count),
  .dma_receive_request(dma_receive_request),
  .dma_transmit_request(dma_transmit_request));
